// ### csb_map.svh
`ifndef CSB_MAP_SVH
`define CSB_MAP_SVH

// value of the management base after a full hardware reset
`define CSB_MGMT_BASE_RST 32'h0000_0000
// idle levels of the synchroniser stages: bit 0 warm reset, bit 1 mgmt irq_n, bit 2 stop_n
`define CSB_SYNC_RST 3'h6
// synchroniser bit positions
`define CSB_SYNC_WARM 0
`define CSB_SYNC_SMI 1
`define CSB_SYNC_STOP 2

`endif

// ### csb_pkg.sv
`default_nettype none

package csb_pkg;

	typedef enum logic [3:0] {
		MS_IDLE = 4'h1,
		MS_PEND = 4'h2,
		MS_ACTIVE = 4'h4,
		MS_RESTORE = 4'h8
	} csb_mstate_t;

	typedef enum logic [4:0] {
		SS_IDLE = 5'h01,
		SS_WAIT = 5'h02,
		SS_DRAIN = 5'h04,
		SS_GRANT = 5'h08,
		SS_STOPPED = 5'h10
	} csb_sstate_t;

	typedef enum logic [2:0] {
		BS_OWN = 3'h1,
		BS_WAIT = 3'h2,
		BS_HOLD = 3'h4
	} csb_bstate_t;

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
	} csb_sync_t;

	typedef struct packed {
		csb_mstate_t mstate;
		logic nested;
		logic entry;
		logic active_n;
		logic smi_prev;
		csb_sstate_t sstate;
		logic halt;
		logic grant_req;
		csb_bstate_t bstate;
		logic ack;
		logic float_bus;
		logic inhibit;
		logic need;
		logic warm_out;
		logic [31:0] base;
	} csb_regs_t;

endpackage
`default_nettype wire

// ### csb_sync.sv
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.svh"

module csb_sync (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic en_i,
	input wire logic [2:0] d_i,
	output logic [2:0] q_o
);

	csb_pkg::csb_sync_t sync_q;
	csb_pkg::csb_sync_t sync_d;

	// first stage feeds only the second stage
	always_comb begin
		sync_d.s1 = d_i;
		sync_d.s2 = sync_q.s1;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync_q <= {`CSB_SYNC_RST, `CSB_SYNC_RST};
		end else if (en_i) begin
			sync_q <= sync_d;
		end
	end

	assign q_o = sync_q.s2;

endmodule
`default_nettype wire

// ### csb_sideband.sv
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.svh"

module csb_sideband (
	input wire logic CLOCK_I,
	input wire logic ARST_N_I,
	input wire logic CLK_EN_I,
	input wire logic WARM_RESET_IN_I,
	input wire logic MGMT_INTERRUPT_N_I,
	input wire logic STOP_CLOCK_REQ_N_I,
	input wire logic BUS_HOLD_REQ_I,
	input wire logic INSTR_BOUNDARY_I,
	input wire logic LOCKED_SEQ_I,
	input wire logic HIGHER_INT_PENDING_I,
	input wire logic RESUME_INSTR_I,
	input wire logic RESTORE_LAST_I,
	input wire logic PIPE_DRAINED_I,
	input wire logic STOP_GRANT_DONE_I,
	input wire logic BUS_NEED_I,
	input wire logic BUS_IDLE_I,
	input wire logic MGMT_BASE_WR_I,
	input wire logic [31:0] MGMT_BASE_DATA_I,
	output logic WARM_RESET_O,
	output logic [31:0] MGMT_MODE_BASE_O,
	output logic MGMT_ENTRY_O,
	output logic MGMT_MODE_ACTIVE_N_O,
	output logic STOP_HALT_O,
	output logic STOP_GRANT_REQ_O,
	output logic BUS_NEED_OUT_O,
	output logic BUS_INHIBIT_O,
	output logic BUS_FLOAT_O,
	output logic BUS_YIELD_ACK_O
);

	localparam csb_pkg::csb_regs_t CSB_RST_ST = '{
		mstate: csb_pkg::MS_IDLE,
		nested: 1'b0,
		entry: 1'b0,
		active_n: 1'b1,
		smi_prev: 1'b1,
		sstate: csb_pkg::SS_IDLE,
		halt: 1'b0,
		grant_req: 1'b0,
		bstate: csb_pkg::BS_OWN,
		ack: 1'b0,
		float_bus: 1'b0,
		inhibit: 1'b0,
		need: 1'b0,
		warm_out: 1'b0,
		base: `CSB_MGMT_BASE_RST
	};

	csb_pkg::csb_regs_t st_q;
	csb_pkg::csb_regs_t st_d;
	logic [2:0] sync_out;
	logic warm_s;
	logic smi_n_s;
	logic stop_n_s;
	logic smi_fall;
	logic take;

	// hold request is already on our clock, so it bypasses the synchroniser
	csb_sync u_sync (
		.clk_i(CLOCK_I),
		.arst_n_i(ARST_N_I),
		.en_i(CLK_EN_I),
		.d_i({STOP_CLOCK_REQ_N_I, MGMT_INTERRUPT_N_I, WARM_RESET_IN_I}),
		.q_o(sync_out)
	);

	assign warm_s = sync_out[`CSB_SYNC_WARM];
	assign smi_n_s = sync_out[`CSB_SYNC_SMI];
	assign stop_n_s = sync_out[`CSB_SYNC_STOP];
	assign smi_fall = st_q.smi_prev & ~smi_n_s;
	// entry waits for a boundary outside any locked sequence
	assign take = (st_q.mstate == csb_pkg::MS_PEND) && INSTR_BOUNDARY_I
		&& !LOCKED_SEQ_I;

	always_comb begin
		st_d = st_q;
		st_d.entry = 1'b0;
		st_d.smi_prev = smi_n_s;
		st_d.need = BUS_NEED_I;
		st_d.warm_out = warm_s;
		if (MGMT_BASE_WR_I) begin
			st_d.base = MGMT_BASE_DATA_I;
		end

		case (st_q.mstate)
			csb_pkg::MS_IDLE: begin
				if (smi_fall) begin
					st_d.mstate = csb_pkg::MS_PEND;
				end
			end
			csb_pkg::MS_PEND: begin
				if (take) begin
					st_d.mstate = csb_pkg::MS_ACTIVE;
					st_d.entry = 1'b1;
				end
			end
			csb_pkg::MS_ACTIVE: begin
				if (smi_fall) begin
					st_d.nested = 1'b1;
				end
				if (RESUME_INSTR_I) begin
					st_d.mstate = csb_pkg::MS_RESTORE;
				end
			end
			csb_pkg::MS_RESTORE: begin
				// a nested edge arriving with the last restore cycle still counts
				if (RESTORE_LAST_I) begin
					st_d.nested = 1'b0;
					if (st_q.nested || smi_fall) begin
						st_d.mstate = csb_pkg::MS_PEND;
					end else begin
						st_d.mstate = csb_pkg::MS_IDLE;
					end
				end else if (smi_fall) begin
					st_d.nested = 1'b1;
				end
			end
			default: begin
				st_d.mstate = csb_pkg::MS_IDLE;
			end
		endcase

		case (st_q.sstate)
			csb_pkg::SS_IDLE: begin
				if (!stop_n_s) begin
					st_d.sstate = csb_pkg::SS_WAIT;
				end
			end
			csb_pkg::SS_WAIT: begin
				// a pending interrupt or mgmt entry at this boundary goes first
				if (INSTR_BOUNDARY_I && !HIGHER_INT_PENDING_I && !take) begin
					st_d.sstate = csb_pkg::SS_DRAIN;
				end
			end
			csb_pkg::SS_DRAIN: begin
				if (PIPE_DRAINED_I) begin
					st_d.sstate = csb_pkg::SS_GRANT;
				end
			end
			csb_pkg::SS_GRANT: begin
				if (STOP_GRANT_DONE_I) begin
					st_d.sstate = csb_pkg::SS_STOPPED;
				end
			end
			csb_pkg::SS_STOPPED: begin
				// the request may only drop after the grant cycle
				if (stop_n_s) begin
					st_d.sstate = csb_pkg::SS_IDLE;
				end
			end
			default: begin
				st_d.sstate = csb_pkg::SS_IDLE;
			end
		endcase

		case (st_q.bstate)
			csb_pkg::BS_OWN: begin
				if (BUS_HOLD_REQ_I) begin
					if (BUS_IDLE_I) begin
						st_d.bstate = csb_pkg::BS_HOLD;
					end else begin
						st_d.bstate = csb_pkg::BS_WAIT;
					end
				end
			end
			csb_pkg::BS_WAIT: begin
				if (!BUS_HOLD_REQ_I) begin
					st_d.bstate = csb_pkg::BS_OWN;
				end else if (BUS_IDLE_I) begin
					st_d.bstate = csb_pkg::BS_HOLD;
				end
			end
			csb_pkg::BS_HOLD: begin
				if (!BUS_HOLD_REQ_I) begin
					st_d.bstate = csb_pkg::BS_OWN;
				end
			end
			default: begin
				st_d.bstate = csb_pkg::BS_OWN;
			end
		endcase

		st_d.active_n = !((st_d.mstate == csb_pkg::MS_ACTIVE)
			|| (st_d.mstate == csb_pkg::MS_RESTORE));
		st_d.halt = (st_d.sstate == csb_pkg::SS_DRAIN) || (st_d.sstate == csb_pkg::SS_GRANT)
			|| (st_d.sstate == csb_pkg::SS_STOPPED);
		st_d.grant_req = (st_d.sstate == csb_pkg::SS_GRANT);
		st_d.ack = (st_d.bstate == csb_pkg::BS_HOLD);
		st_d.float_bus = (st_d.bstate == csb_pkg::BS_HOLD);
		// new cycles are held back as soon as a hold is pending
		st_d.inhibit = (st_d.bstate != csb_pkg::BS_OWN);

		// warm reset acts like a full reset but the base survives
		if (warm_s) begin
			st_d = CSB_RST_ST;
			st_d.base = st_q.base;
			st_d.smi_prev = smi_n_s;
			st_d.warm_out = 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			st_q <= CSB_RST_ST;
		end else if (CLK_EN_I) begin
			st_q <= st_d;
		end
	end

	assign WARM_RESET_O = st_q.warm_out;
	assign MGMT_MODE_BASE_O = st_q.base;
	assign MGMT_ENTRY_O = st_q.entry;
	assign MGMT_MODE_ACTIVE_N_O = st_q.active_n;
	assign STOP_HALT_O = st_q.halt;
	assign STOP_GRANT_REQ_O = st_q.grant_req;
	assign BUS_NEED_OUT_O = st_q.need;
	assign BUS_INHIBIT_O = st_q.inhibit;
	assign BUS_FLOAT_O = st_q.float_bus;
	assign BUS_YIELD_ACK_O = st_q.ack;

	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!ARST_N_I);

	sequence s_take_mgmt;
		CLK_EN_I && !warm_s && take;
	endsequence

	sequence s_enter_mgmt;
		MGMT_ENTRY_O && !MGMT_MODE_ACTIVE_N_O && (st_q.mstate == csb_pkg::MS_ACTIVE);
	endsequence

	warm_keeps_base_a: assert property (
		(CLK_EN_I && warm_s && !MGMT_BASE_WR_I) |=> $stable(MGMT_MODE_BASE_O)
			&& MGMT_MODE_ACTIVE_N_O && !BUS_YIELD_ACK_O && WARM_RESET_O)
		else $error("warm reset disturbed base or left state");

	mgmt_entry_a: assert property (
		s_take_mgmt |=> s_enter_mgmt)
		else $error("mgmt entry not taken at boundary");

	entry_needs_boundary_a: assert property (
		$rose(MGMT_ENTRY_O) |-> $past(INSTR_BOUNDARY_I) && !$past(LOCKED_SEQ_I))
		else $error("mgmt entry outside boundary or in lock");

	no_reentry_a: assert property (
		(st_q.mstate == csb_pkg::MS_ACTIVE) && CLK_EN_I && !warm_s && !RESUME_INSTR_I
			|=> (st_q.mstate == csb_pkg::MS_ACTIVE) && !MGMT_ENTRY_O)
		else $error("handler interrupted by mgmt irq");

	nested_serve_a: assert property (
		(st_q.mstate == csb_pkg::MS_RESTORE) && st_q.nested && RESTORE_LAST_I && CLK_EN_I
			&& !warm_s |=> (st_q.mstate == csb_pkg::MS_PEND) && MGMT_MODE_ACTIVE_N_O)
		else $error("nested mgmt edge lost after resume");

	active_ind_a: assert property (
		($fell(MGMT_MODE_ACTIVE_N_O) |-> MGMT_ENTRY_O)
			and ($rose(MGMT_MODE_ACTIVE_N_O) |-> $past(RESTORE_LAST_I) || $past(warm_s)))
		else $error("mgmt active indicator out of step");

	stop_grant_a: assert property (
		(st_q.sstate == csb_pkg::SS_DRAIN) && PIPE_DRAINED_I && CLK_EN_I && !warm_s
			|=> STOP_GRANT_REQ_O && STOP_HALT_O)
		else $error("no stop-grant after drain");

	bus_need_a: assert property (
		CLK_EN_I && !warm_s |=> BUS_NEED_OUT_O == $past(BUS_NEED_I))
		else $error("bus need does not follow core");

	hold_after_cycle_a: assert property (
		$rose(BUS_YIELD_ACK_O) |-> $past(BUS_IDLE_I) && $past(BUS_HOLD_REQ_I))
		else $error("bus yielded during a cycle");

	hold_stays_a: assert property (
		BUS_YIELD_ACK_O && BUS_HOLD_REQ_I && CLK_EN_I && !warm_s |=> BUS_YIELD_ACK_O)
		else $error("bus taken back while hold high");

	ack_with_float_a: assert property (
		(BUS_YIELD_ACK_O == BUS_FLOAT_O) && (BUS_FLOAT_O -> BUS_INHIBIT_O))
		else $error("ack and float disagree");

endmodule
`default_nettype wire

// ### csb_partner.sv
`timescale 1ns/1ns
`default_nettype none

// other bus master and system controller on the far side
module csb_partner (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic hold_want_i,
	input wire logic stop_go_i,
	input wire logic grant_req_i,
	input wire logic grant_done_i,
	output logic hold_req_o,
	output logic stop_n_o
);
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hold_req_o <= 1'h0;
			stop_n_o <= 1'h1;
		end else begin
			hold_req_o <= hold_want_i;
			// request kept low until the stop-grant cycle is seen
			if (stop_go_i)
				stop_n_o <= 1'h0;
			else if (grant_req_i && grant_done_i)
				stop_n_o <= 1'h1;
		end
	end
endmodule
`default_nettype wire

// ### csb_sideband_tb.sv
`timescale 1ns/1ns
`default_nettype none

module csb_sideband_tb;
	logic clk, rst_n, en, warm, irq_n, hw, sgo, bnd, lck, hi, res, last, dr, done, need, idl, wr;
	logic [31:0] wd;
	logic hold, stop_n, w_o, ent, act_n, halt, greq, need_o, inh, flt, ack;
	logic [31:0] base;
	int fails = 0;
	int n_tests = 0;

	csb_sideband u_dut (.CLOCK_I(clk), .ARST_N_I(rst_n), .CLK_EN_I(en),
		.WARM_RESET_IN_I(warm), .MGMT_INTERRUPT_N_I(irq_n),
		.STOP_CLOCK_REQ_N_I(stop_n), .BUS_HOLD_REQ_I(hold),
		.INSTR_BOUNDARY_I(bnd), .LOCKED_SEQ_I(lck), .HIGHER_INT_PENDING_I(hi),
		.RESUME_INSTR_I(res), .RESTORE_LAST_I(last), .PIPE_DRAINED_I(dr),
		.STOP_GRANT_DONE_I(done), .BUS_NEED_I(need), .BUS_IDLE_I(idl),
		.MGMT_BASE_WR_I(wr), .MGMT_BASE_DATA_I(wd), .WARM_RESET_O(w_o),
		.MGMT_MODE_BASE_O(base), .MGMT_ENTRY_O(ent), .MGMT_MODE_ACTIVE_N_O(act_n),
		.STOP_HALT_O(halt), .STOP_GRANT_REQ_O(greq), .BUS_NEED_OUT_O(need_o),
		.BUS_INHIBIT_O(inh), .BUS_FLOAT_O(flt), .BUS_YIELD_ACK_O(ack));

	csb_partner u_far (.clk_i(clk), .arst_n_i(rst_n), .hold_want_i(hw),
		.stop_go_i(sgo), .grant_req_i(greq), .grant_done_i(done),
		.hold_req_o(hold), .stop_n_o(stop_n));

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic tally_and_finish;
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic t_reset;
		chk("act_n", 32'h1, act_n);
		chk("ack", 32'h0, ack);
		chk("base", 32'h0, base);
		chk("halt", 32'h0, halt);
	endtask

	task automatic t_need;
		need = 1'h1;
		cyc(1);
		chk("need_o", 32'h1, need_o);
		need = 1'h0;
		cyc(1);
		chk("need_o", 32'h0, need_o);
	endtask

	// with the enable low nothing may move, not even the bus need copy
	task automatic t_freeze;
		en = 1'h0;
		need = 1'h1;
		cyc(3);
		chk("need_o", 32'h0, need_o);
		en = 1'h1;
		cyc(1);
		chk("need_o", 32'h1, need_o);
		need = 1'h0;
		cyc(1);
		chk("need_o", 32'h0, need_o);
	endtask

	task automatic t_hold;
		idl = 1'h0;
		hw = 1'h1;
		cyc(4);
		chk("inh", 32'h1, inh);
		chk("ack", 32'h0, ack);
		idl = 1'h1;
		cyc(1);
		chk("ack", 32'h1, ack);
		chk("flt", 32'h1, flt);
		cyc(4);
		chk("ack", 32'h1, ack);
		hw = 1'h0;
		cyc(2);
		chk("ack", 32'h0, ack);
		chk("inh", 32'h0, inh);
	endtask

	task automatic pulse_bnd(input logic exp);
		bnd = 1'h1;
		cyc(1);
		bnd = 1'h0;
		chk("ent", {31'h0, exp}, ent);
	endtask

	task automatic leave_mgmt;
		res = 1'h1;
		cyc(1);
		res = 1'h0;
		chk("act_n", 32'h0, act_n);
		last = 1'h1;
		cyc(1);
		last = 1'h0;
		chk("act_n", 32'h1, act_n);
	endtask

	task automatic t_mgmt;
		irq_n = 1'h0;
		cyc(5);
		chk("ent", 32'h0, ent);
		lck = 1'h1;
		pulse_bnd(1'h0);
		lck = 1'h0;
		pulse_bnd(1'h1);
		cyc(1);
		chk("ent", 32'h0, ent);
		chk("act_n", 32'h0, act_n);
		irq_n = 1'h1;
		cyc(3);
		irq_n = 1'h0;
		cyc(4);
		pulse_bnd(1'h0);
		irq_n = 1'h1;
		leave_mgmt();
		pulse_bnd(1'h1);
		leave_mgmt();
	endtask

	task automatic t_stop;
		sgo = 1'h1;
		cyc(1);
		sgo = 1'h0;
		cyc(4);
		hi = 1'h1;
		pulse_bnd(1'h0);
		cyc(1);
		chk("halt", 32'h0, halt);
		hi = 1'h0;
		bnd = 1'h1;
		cyc(1);
		bnd = 1'h0;
		chk("halt", 32'h1, halt);
		cyc(2);
		chk("greq", 32'h0, greq);
		dr = 1'h1;
		cyc(2);
		chk("greq", 32'h1, greq);
		done = 1'h1;
		cyc(1);
		done = 1'h0;
		dr = 1'h0;
		chk("greq", 32'h0, greq);
		cyc(4);
		chk("halt", 32'h0, halt);
	endtask

	task automatic t_warm;
		wr = 1'h1;
		wd = 32'hA5C3_0F1E;
		cyc(1);
		wr = 1'h0;
		hw = 1'h1;
		idl = 1'h1;
		cyc(3);
		chk("ack", 32'h1, ack);
		// hold stays requested, so only the warm reset can drop the grant
		warm = 1'h1;
		cyc(15);
		chk("w_o", 32'h1, w_o);
		chk("ack", 32'h0, ack);
		chk("base", 32'hA5C3_0F1E, base);
		warm = 1'h0;
		hw = 1'h0;
		cyc(4);
		chk("w_o", 32'h0, w_o);
		chk("base", 32'hA5C3_0F1E, base);
		chk("ack", 32'h0, ack);
	endtask

	// a full reset in mid-run must clear the base that warm reset kept
	task automatic t_full_reset;
		hw = 1'h1;
		cyc(3);
		chk("ack", 32'h1, ack);
		rst_n = 1'h0;
		hw = 1'h0;
		cyc(2);
		chk("base", 32'h0, base);
		chk("ack", 32'h0, ack);
		rst_n = 1'h1;
		cyc(2);
		chk("base", 32'h0, base);
		chk("ack", 32'h0, ack);
		chk("act_n", 32'h1, act_n);
	endtask

	initial begin
		{warm, hw, sgo, bnd, lck, hi, res, last, dr, done, need, idl, wr} = 13'h0;
		en = 1'h1;
		irq_n = 1'h1;
		wd = 32'h0;
		rst_n = 1'h0;
		cyc(12);
		rst_n = 1'h1;
		cyc(1);
		t_reset();
		t_need();
		t_freeze();
		t_hold();
		t_mgmt();
		t_stop();
		t_warm();
		t_full_reset();
		tally_and_finish();
	end

	// the whole sequence needs about a hundred cycles
	initial begin
		#80000;
		fails++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
